// ### hw/tecl_top.sv
`timescale 1ns/1ps
`include "tecl_consts.svh"
module tecl_top #(
   parameter int CLR_CYC = `TECL_CYC_UP(`TECL_CLR_NS), // Clear pulse length.
   parameter int STRETCH_CYC = `TECL_CYC_UP(`TECL_STRETCH_NS), // Launch stretch length.
   parameter int PEND_DLY_CYC = `TECL_CYC_UP(`TECL_PEND_DLY_NS) // Pending drop delay.
) (
   input wire logic pclk, // APB clock.
   input wire logic presetn, // Async reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire tecl_pkg::tecl_mem_t mem_in, // Cache side inputs.
   output tecl_pkg::tecl_mout_t mem_out, // Cache side outputs.
   input wire logic host_init, // Host bus initialize.
   input wire logic power_low, // Power low.
   input wire logic ctrl_ready, // Controller in ready state.
   input wire logic word_count_overflow, // Word count overflow.
   input wire logic [15:0] buffer_output_word, // Data buffer output word.
   output logic clear_pulse, // Clears controller and drive.
   output logic buffer_initialize, // Data buffer init.
   output logic selected_bits_reset, // Clears selected bits.
   output logic burst_start // Drives the drive-bus run line.
);
   import tecl_pkg::*;

   logic odd_word_parity_fault;
   logic even_word_parity_fault;
   logic address_parity_fault;
   logic missing_memory_fault;
   logic pending_clear_flag;
   logic [15:0] first_control_status_reg;
   logic [15:0] cs2_store;
   logic [15:0] cs3_store;
   logic [4:0] cycle_cnt;
   logic [7:0] clr_cnt;
   logic [7:0] stretch_cnt;
   tecl_clr_st_t clr_st;
   logic acc;
   logic wr;
   logic rd;
   logic unmapped;
   logic transfer_launch_reset;
   logic program_clear;
   logic error_flag_clear;
   logic odd_en;
   logic even_en;
   logic timeout_sel;
   logic combined_parity_error;
   logic fire;
   logic next_done;
   logic [15:0] host_read_mux;

   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   assign rd = psel & penable & ~pready & ~pwrite;
   assign unmapped = paddr != `TECL_OFS_CS1 && paddr != `TECL_OFS_CS2 && paddr != `TECL_OFS_CS3
                     && paddr != `TECL_OFS_DB && paddr != `TECL_OFS_STAT;
   assign transfer_launch_reset = wr & (paddr == `TECL_OFS_CS1) & pwdata[`TECL_CS1_GO];
   assign program_clear = wr & (paddr == `TECL_OFS_CS2) & pwdata[`TECL_CS2_CLR];
   // Errors are cleared by the same sources that reset the selected bits, plus the clear pulse.
   assign error_flag_clear = selected_bits_reset | clear_pulse;
   assign odd_en = mem_in.xfer_write & mem_in.odd_word;
   assign even_en = mem_in.xfer_write & mem_in.even_word;
   assign timeout_sel = mem_in.cache_timeout & mem_in.controller_select;
   assign combined_parity_error = odd_word_parity_fault | even_word_parity_fault
                                  | address_parity_fault;
   // Done waits for any cycle already running; with ctrl_ready high a clear fires without waiting for done or the cycle.
   assign next_done = (pending_clear_flag | odd_word_parity_fault | even_word_parity_fault)
                      & ~mem_in.cycle_in_progress;
   assign fire = pending_clear_flag & (mem_out.transfer_done | ctrl_ready);

   // APB slave: one wait state, registered answer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & unmapped;
      end
   end

   always_comb begin
      host_read_mux = `TECL_REG_RST;
      unique case (paddr)
         `TECL_OFS_CS1: host_read_mux = first_control_status_reg;
         `TECL_OFS_CS2: begin
            host_read_mux = cs2_store;
            host_read_mux[`TECL_CS2_NEM] = missing_memory_fault;
            host_read_mux[`TECL_CS2_PE] = combined_parity_error;
         end
         `TECL_OFS_CS3: begin
            host_read_mux = cs3_store;
            host_read_mux[`TECL_CS3_APF] = address_parity_fault;
            host_read_mux[`TECL_CS3_ODD] = odd_word_parity_fault;
            host_read_mux[`TECL_CS3_EVEN] = even_word_parity_fault;
         end
         `TECL_OFS_DB: host_read_mux = cs3_store[`TECL_CS3_MAINT] ? buffer_output_word : `TECL_REG_RST;
         `TECL_OFS_STAT: host_read_mux = {8'h00, pending_clear_flag, burst_start, clr_st == CL_PULSE,
                                          cycle_cnt};
         default: host_read_mux = `TECL_REG_RST;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         prdata <= {16'h0000, host_read_mux};
      end else if (acc) begin
         prdata <= 32'h0000_0000;
      end
   end

   // Stored control bits; the go and clear bits act as strobes and are not kept.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_control_status_reg <= `TECL_REG_RST;
         cs2_store <= `TECL_REG_RST;
         cs3_store <= `TECL_REG_RST;
      end else if (selected_bits_reset) begin
         cs3_store <= `TECL_REG_RST;
      end else if (wr) begin
         if (paddr == `TECL_OFS_CS1) begin
            first_control_status_reg <= pwdata[15:0];
            first_control_status_reg[`TECL_CS1_GO] <= 1'b0;
         end
         if (paddr == `TECL_OFS_CS2) begin
            cs2_store <= pwdata[15:0];
            cs2_store[`TECL_CS2_CLR] <= 1'b0;
            cs2_store[`TECL_CS2_NEM] <= 1'b0;
            cs2_store[`TECL_CS2_PE] <= 1'b0;
         end
         if (paddr == `TECL_OFS_CS3) begin
            cs3_store <= {3'h0, pwdata[12:0]};
         end
      end
   end

   // Data parity faults; a new error in the clearing cycle still sets.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odd_word_parity_fault <= 1'b0;
         even_word_parity_fault <= 1'b0;
      end else begin
         if (mem_in.req_clk & odd_en & (mem_in.odd_high_byte_parity_flag | mem_in.odd_low_byte_parity_flag)) begin
            odd_word_parity_fault <= 1'b1;
         end else if (error_flag_clear) begin
            odd_word_parity_fault <= 1'b0;
         end
         if (mem_in.req_clk & even_en
             & (mem_in.even_high_byte_parity_flag | mem_in.even_low_byte_parity_flag)) begin
            even_word_parity_fault <= 1'b1;
         end else if (error_flag_clear) begin
            even_word_parity_fault <= 1'b0;
         end
      end
   end

   // The cache reports address parity alongside the timeout for this controller.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         address_parity_fault <= 1'b0;
         missing_memory_fault <= 1'b0;
      end else begin
         if (timeout_sel & mem_in.cache_address_parity_report) begin
            address_parity_fault <= 1'b1;
         end else if (error_flag_clear) begin
            address_parity_fault <= 1'b0;
         end
         if (timeout_sel & ~mem_in.cache_address_parity_report) begin
            missing_memory_fault <= 1'b1;
         end else if (error_flag_clear) begin
            missing_memory_fault <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_out <= '0;
      end else begin
         mem_out.odd_word_check_enable <= odd_en;
         mem_out.even_word_check_enable <= even_en;
         mem_out.request_hold <= odd_word_parity_fault | even_word_parity_fault
                                 | pending_clear_flag;
         mem_out.transfer_done <= next_done;
      end
   end

   // Pending clear: a fresh request wins over the delayed drop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_clear_flag <= 1'b0;
      end else if (program_clear | host_init) begin
         pending_clear_flag <= 1'b1;
      end else if (clr_st == CL_PULSE && clr_cnt == 8'(PEND_DLY_CYC)) begin
         pending_clear_flag <= 1'b0;
      end
   end

   // Clear one-shot; it counts elapsed cycles so the pending drop can be timed off it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_st <= CL_IDLE;
         clr_cnt <= 8'h00;
         clear_pulse <= 1'b0;
      end else begin
         unique case (clr_st)
            CL_IDLE: begin
               if (fire) begin
                  clr_st <= CL_PULSE;
                  clr_cnt <= 8'h01;
                  clear_pulse <= 1'b1;
               end
            end
            CL_PULSE: begin
               if (clr_cnt == 8'(CLR_CYC)) begin
                  clr_st <= CL_IDLE;
                  clr_cnt <= 8'h00;
                  clear_pulse <= 1'b0;
               end else begin
                  clr_cnt <= clr_cnt + 8'h01;
               end
            end
         endcase
      end
   end

   // Launch stretch; a repeat launch restarts the full length.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stretch_cnt <= 8'h00;
      end else if (transfer_launch_reset) begin
         stretch_cnt <= 8'(STRETCH_CYC);
      end else if (stretch_cnt != 8'h00) begin
         stretch_cnt <= stretch_cnt - 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buffer_initialize <= 1'b0;
         selected_bits_reset <= 1'b0;
      end else begin
         buffer_initialize <= transfer_launch_reset | (stretch_cnt > 8'h01) | power_low
                              | fire | (clear_pulse & clr_cnt != 8'(CLR_CYC));
         selected_bits_reset <= transfer_launch_reset | power_low | pending_clear_flag;
      end
   end

   // Four counter: bit 4 is the carry and freezes the count once set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_cnt <= `TECL_CNT_LOAD;
      end else if (transfer_launch_reset) begin
         cycle_cnt <= `TECL_CNT_LOAD;
      end else if (mem_in.mem_cycle & ~cycle_cnt[`TECL_CNT_CARRY]) begin
         cycle_cnt <= cycle_cnt + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_start <= 1'b0;
      end else begin
         burst_start <= ~transfer_launch_reset
                        & (cycle_cnt[`TECL_CNT_CARRY] | word_count_overflow);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_pulse_start;
      $rose(clear_pulse);
   endsequence
   sequence s_pulse_body;
      clear_pulse [*8];
   endsequence

   a_odd_fault_set: assert property (mem_in.req_clk && odd_en && mem_in.odd_low_byte_parity_flag
      |=> odd_word_parity_fault) else $error("odd fault not set");
   a_even_fault_set: assert property (mem_in.req_clk && even_en && mem_in.even_high_byte_parity_flag
      |=> even_word_parity_fault) else $error("even fault not set");
   a_req_hold_fault: assert property (odd_word_parity_fault || even_word_parity_fault
      |=> mem_out.request_hold) else $error("request not held on fault");
   a_pe_combined: assert property (rd && paddr == `TECL_OFS_CS2 && address_parity_fault
      |=> prdata[`TECL_CS2_PE]) else $error("combined parity bit missing");
   a_clear_errors: assert property (error_flag_clear && !timeout_sel && !mem_in.req_clk
      |=> !address_parity_fault && !missing_memory_fault) else $error("faults not cleared");
   a_timeout_split: assert property (timeout_sel && mem_in.cache_address_parity_report
      && !missing_memory_fault |=> address_parity_fault && !missing_memory_fault)
      else $error("address timeout set missing memory");
   a_pending_set: assert property (program_clear || host_init |=> pending_clear_flag)
      else $error("pending clear not set");
   a_ready_fire: assert property (pending_clear_flag && ctrl_ready && clr_st == CL_IDLE
      |=> clear_pulse) else $error("clear pulse not immediate");
   a_pulse_len: assert property (s_pulse_start |-> s_pulse_body ##1 !clear_pulse)
      else $error("clear pulse length wrong");
   a_pending_drop: assert property ((s_pulse_start and (!program_clear && !host_init))
      ##1 (!program_clear && !host_init) [*2] |=> !pending_clear_flag)
      else $error("pending clear not dropped");
   a_count_sat: assert property (cycle_cnt[`TECL_CNT_CARRY] && !transfer_launch_reset
      |=> $stable(cycle_cnt)) else $error("counter passed four");
   // The model spaces memory cycles apart, so the load and the fourth count are checked separately.
   a_count_load: assert property (transfer_launch_reset |=> cycle_cnt == `TECL_CNT_LOAD)
      else $error("counter not loaded on launch");
   a_burst_four: assert property (mem_in.mem_cycle && !transfer_launch_reset && cycle_cnt == `TECL_CNT_LAST
      |=> cycle_cnt[`TECL_CNT_CARRY] ##1 burst_start) else $error("burst start missing");
   a_word_count_overflow: assert property (word_count_overflow && !transfer_launch_reset |=> burst_start)
      else $error("overflow burst start missing");
endmodule // tecl_top

// ### shared/tecl_consts.svh
`ifndef TECL_CONSTS_SVH
`define TECL_CONSTS_SVH
`define TECL_CLK_NS 50
`define TECL_CLR_NS 400
`define TECL_STRETCH_NS 400
`define TECL_PEND_DLY_NS 100
`define TECL_CYC_UP(ns) (((ns) + `TECL_CLK_NS - 1) / `TECL_CLK_NS)
`define TECL_OFS_CS1 12'h000
`define TECL_OFS_CS2 12'h004
`define TECL_OFS_CS3 12'h008
`define TECL_OFS_DB 12'h00c
`define TECL_OFS_STAT 12'h010
`define TECL_CS1_GO 0
`define TECL_CS2_CLR 5
`define TECL_CS2_NEM 11
`define TECL_CS2_PE 13
`define TECL_CS3_MAINT 0
`define TECL_CS3_EVEN 13
`define TECL_CS3_ODD 14
`define TECL_CS3_APF 15
`define TECL_CNT_LOAD 5'h0c
`define TECL_CNT_LAST 5'h0f
`define TECL_CNT_CARRY 4
`define TECL_REG_RST 16'h0000
`endif

// ### shared/tecl_pkg.sv
package tecl_pkg;
   typedef struct packed {
      logic xfer_write;
      logic odd_word;
      logic even_word;
      logic odd_high_byte_parity_flag;
      logic odd_low_byte_parity_flag;
      logic even_high_byte_parity_flag;
      logic even_low_byte_parity_flag;
      logic req_clk;
      logic cache_timeout;
      logic cache_address_parity_report;
      logic controller_select;
      logic mem_cycle;
      logic cycle_in_progress;
   } tecl_mem_t;
   typedef struct packed {
      logic odd_word_check_enable;
      logic even_word_check_enable;
      logic request_hold;
      logic transfer_done;
   } tecl_mout_t;
   typedef enum logic [1:0] {
      CL_IDLE = 2'b00,
      CL_PULSE = 2'b01
   } tecl_clr_st_t;
endpackage

// ### test/tecl_cache_model.sv
`timescale 1ns/1ps
module tecl_cache_model (
   input wire logic pclk, // Controller clock.
   output tecl_pkg::tecl_mem_t mem // Cache side signals seen by the block.
);
   import tecl_pkg::*;
   initial mem = '0;
   // Qualifiers settle one edge ahead of the request clock, as a real data path would.
   task automatic xfer(input logic odd, input logic even, input logic [3:0] flags);
      @(posedge pclk);
      mem.xfer_write <= 1'b1;
      mem.odd_word <= odd;
      mem.even_word <= even;
      {mem.odd_high_byte_parity_flag, mem.odd_low_byte_parity_flag, mem.even_high_byte_parity_flag,
         mem.even_low_byte_parity_flag} <= flags;
      @(posedge pclk);
      mem.req_clk <= 1'b1;
      @(posedge pclk);
      mem.req_clk <= 1'b0;
      mem.xfer_write <= 1'b0;
      mem.odd_word <= 1'b0;
      mem.even_word <= 1'b0;
      // Stale flag lines must not look like a held value.
      {mem.odd_high_byte_parity_flag, mem.odd_low_byte_parity_flag, mem.even_high_byte_parity_flag,
         mem.even_low_byte_parity_flag} <= ~flags;
   endtask
   task automatic tmo(input logic sel, input logic apar);
      @(posedge pclk);
      mem.controller_select <= sel;
      mem.cache_address_parity_report <= apar;
      mem.cache_timeout <= 1'b1;
      @(posedge pclk);
      mem.cache_timeout <= 1'b0;
      mem.cache_address_parity_report <= 1'b0;
      mem.controller_select <= 1'b0;
   endtask
   task automatic cycles(input int n);
      repeat (n) begin
         @(posedge pclk);
         mem.mem_cycle <= 1'b1;
         @(posedge pclk);
         mem.mem_cycle <= 1'b0;
      end
   endtask
   task automatic set_cip(input logic v);
      @(posedge pclk);
      mem.cycle_in_progress <= v;
   endtask
endmodule // tecl_cache_model

// ### test/tecl_top_tb.sv
`timescale 1ns/1ps
module tecl_top_tb;
   import tecl_pkg::*;
   localparam int CLR_CYC = 8;
   localparam int STR_CYC = 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, last_err;
   tecl_mem_t mem_in;
   tecl_mout_t mem_out;
   logic host_init = 1'b0, power_low = 1'b0, ctrl_ready = 1'b1, word_count_overflow = 1'b0;
   logic [15:0] buffer_output_word = 16'ha5c3;
   logic clear_pulse, buffer_initialize, selected_bits_reset, burst_start, done_v;
   logic [2:0] seen = 3'b000;
   int fail_count = 0;
   int n_compared = 0;
   int w;
   assign done_v = mem_out.transfer_done;
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      if (done_v === 1'b1) seen[2] <= 1'b1;
      if (buffer_initialize === 1'b1) seen[1] <= 1'b1;
      if (selected_bits_reset === 1'b1) seen[0] <= 1'b1;
   end
   tecl_cache_model tecl_cache_model_inst (.pclk(pclk), .mem(mem_in));
   tecl_top #(.CLR_CYC(CLR_CYC), .STRETCH_CYC(STR_CYC), .PEND_DLY_CYC(2)) tecl_top_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_in(mem_in),
      .mem_out(mem_out), .host_init(host_init), .power_low(power_low), .ctrl_ready(ctrl_ready),
      .word_count_overflow(word_count_overflow), .buffer_output_word(buffer_output_word),
      .clear_pulse(clear_pulse), .buffer_initialize(buffer_initialize),
      .selected_bits_reset(selected_bits_reset), .burst_start(burst_start));
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang;
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, 32'h0, 32'h1);
      end_sim;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) hang();
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q & m, exp);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   // Waits for a rise, then counts the cycles the signal stays high.
   task automatic pulse_len(ref logic s, output int n);
      int k;
      k = 0;
      n = 0;
      while (s !== 1'b1 && k < 100) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 100) hang();
      while (s === 1'b1 && n < 100) begin
         n++;
         @(posedge pclk);
      end
   endtask
   task automatic do_clear;
      wr(12'h004, 32'h00000020);
      pulse_len(clear_pulse, w);
      chk(w, CLR_CYC);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      rd(12'h008, 32'h0);
      rd(12'h014, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      rd(12'h010, 32'h0000000c, 32'h1f);
      tecl_cache_model_inst.xfer(1'b1, 1'b0, 4'b1000);
      chk({30'h0, mem_out.odd_word_check_enable, mem_out.even_word_check_enable}, 32'h2);
      repeat (2) @(posedge pclk);
      chk({31'h0, mem_out.request_hold}, 32'h1);
      rd(12'h008, 32'h00004000);
      rd(12'h004, 32'h00002000);
      do_clear();
      rd(12'h008, 32'h0);
      chk({31'h0, mem_out.request_hold}, 32'h0);
      tecl_cache_model_inst.xfer(1'b0, 1'b1, 4'b0001);
      chk({30'h0, mem_out.odd_word_check_enable, mem_out.even_word_check_enable}, 32'h1);
      rd(12'h008, 32'h00002000);
      do_clear();
      tecl_cache_model_inst.xfer(1'b1, 1'b1, 4'b1010);
      chk({30'h0, mem_out.odd_word_check_enable, mem_out.even_word_check_enable}, 32'h3);
      rd(12'h008, 32'h00006000);
      do_clear();
      tecl_cache_model_inst.xfer(1'b0, 1'b1, 4'b1000);
      rd(12'h008, 32'h0);
      tecl_cache_model_inst.tmo(1'b0, 1'b0);
      rd(12'h004, 32'h0);
      tecl_cache_model_inst.tmo(1'b1, 1'b0);
      rd(12'h004, 32'h00000800);
      do_clear();
      tecl_cache_model_inst.tmo(1'b1, 1'b1);
      rd(12'h008, 32'h00008000);
      rd(12'h004, 32'h00002000);
      do_clear();
      rd(12'h010, 32'h0, 32'h80);
      // Clear requested while a memory cycle is still running.
      ctrl_ready <= 1'b0;
      tecl_cache_model_inst.set_cip(1'b1);
      wr(12'h004, 32'h00000020);
      repeat (10) @(posedge pclk);
      chk({31'h0, clear_pulse}, 32'h0);
      seen <= 3'b000;
      tecl_cache_model_inst.set_cip(1'b0);
      pulse_len(clear_pulse, w);
      chk(w, CLR_CYC);
      chk({29'h0, seen}, 32'h7);
      ctrl_ready <= 1'b1;
      host_init <= 1'b1;
      @(posedge pclk);
      host_init <= 1'b0;
      pulse_len(clear_pulse, w);
      chk(w, CLR_CYC);
      wr(12'h000, 32'h00000001);
      pulse_len(buffer_initialize, w);
      chk(w, STR_CYC);
      rd(12'h010, 32'h0000000c, 32'h5f);
      tecl_cache_model_inst.cycles(3);
      rd(12'h010, 32'h0000000f, 32'h5f);
      tecl_cache_model_inst.cycles(1);
      rd(12'h010, 32'h00000050, 32'h5f);
      tecl_cache_model_inst.cycles(3);
      rd(12'h010, 32'h00000050, 32'h5f);
      wr(12'h000, 32'h00000001);
      repeat (2) @(posedge pclk);
      chk({31'h0, burst_start}, 32'h0);
      word_count_overflow <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({31'h0, burst_start}, 32'h1);
      word_count_overflow <= 1'b0;
      wr(12'h008, 32'h00000001);
      rd(12'h008, 32'h00000001);
      rd(12'h00c, 32'h0000a5c3);
      buffer_output_word <= 16'h3c5a;
      rd(12'h00c, 32'h00003c5a);
      wr(12'h008, 32'h0);
      rd(12'h00c, 32'h0);
      power_low <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({31'h0, buffer_initialize}, 32'h1);
      chk({31'h0, selected_bits_reset}, 32'h1);
      power_low <= 1'b0;
      end_sim();
   end
endmodule // tecl_top_tb
